//--- inc/dii_consts.svh
/*
 * Constants of the drive input interpreter: register address, field
 * positions, reset value, input midpoint and timing figures.
 * Assumes inclusion by bare name from design and bench files.
 */
`ifndef DII_CONSTS_SVH
`define DII_CONSTS_SVH

// ==========================================================
// register map
`define DII_CTRL_ADDR 8'h1C
`define DII_CTRL_RST 8'hF5
`define DII_POL_BIT 7
`define DII_BGR_BIT 6
`define DII_ST_HI 5
`define DII_ST_LO 4
`define DII_BLK_HI 3
`define DII_BLK_LO 2
`define DII_DEC_HI 1
`define DII_DEC_LO 0

// ==========================================================
// drive code
`define DII_MID_CODE 8'h80
`define DII_SIGN_FLIP 8'h80
`define DII_ZERO_AMP 9'h000

// ==========================================================
// timing
`define DII_CLK_NS 10
`define DII_NS_PER_US 1000
`define DII_ST0_US 150
`define DII_ST1_US 200
`define DII_ST2_US 250
`define DII_ST3_US 300

`endif

//--- inc/dii_pkg.sv
/*
 * Types of the drive input interpreter.
 * Assumes nothing of its surroundings.
 */
package dii_pkg;

  typedef logic signed [8:0] dii_amp_t;
  typedef logic [15:0] dii_cyc_t;

  typedef enum logic [1:0] {
    DII_UNIDIR,
    DII_BIDIR_OPEN,
    DII_BIDIR_CLOSED
  } dii_mode_t;

endpackage : dii_pkg

//--- inc/dii_tmr_if.sv
/*
 * Link between the interpreter and its sampling-period timer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface dii_tmr_if;
  logic [15:0] period_cycles;
  logic tick;

  modport ctrl (output period_cycles, input tick);
  modport tmr (input period_cycles, output tick);
endinterface : dii_tmr_if

//--- hw/dii_sample_timer.sv
/*
 * Resonance sampling-period timer: one-cycle tick every period_cycles
 * clocks; restarts when the period changes.
 * Assumes period_cycles is at least one and comes from the same clock.
 */
`timescale 1ns/1ps
module dii_sample_timer (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // link to interpreter
  dii_tmr_if.tmr tmr
);
  import dii_pkg::*;

  // ==========================================================
  // counter
  dii_cyc_t count;
  dii_cyc_t last_period;
  logic tick_q;
  wire logic period_changed = (last_period != tmr.period_cycles);
  wire logic at_end = (count <= 16'h0001);
  wire dii_cyc_t next_count = (period_changed || at_end) ?
                              tmr.period_cycles : count - 16'h0001;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= 16'h0000;
      last_period <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      count <= next_count;
      last_period <= tmr.period_cycles;
      tick_q <= at_end && !period_changed;
    end
  end

  assign tmr.tick = tick_q;

endmodule : dii_sample_timer

//--- hw/dii_top.sv
/*
 * Drive input interpreter: control register, mapping of input drive
 * codes to signed amplitude, braking decision, brake gain reduction and
 * resonance sampling tick.
 * Assumes drive codes, loop mode and feedback flags come from logic on
 * i_clk_sys; the register port is the device's internal register access.
 */
`timescale 1ns/1ps
`include "dii_consts.svh"
module dii_top #(
  parameter logic [15:0] P_SAMPLE_CYC_0 =
    16'(`DII_ST0_US * `DII_NS_PER_US / `DII_CLK_NS),
  parameter logic [15:0] P_SAMPLE_CYC_1 =
    16'(`DII_ST1_US * `DII_NS_PER_US / `DII_CLK_NS),
  parameter logic [15:0] P_SAMPLE_CYC_2 =
    16'(`DII_ST2_US * `DII_NS_PER_US / `DII_CLK_NS),
  parameter logic [15:0] P_SAMPLE_CYC_3 =
    16'(`DII_ST3_US * `DII_NS_PER_US / `DII_CLK_NS)
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // register access
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // drive input and loop state
  input wire logic [7:0] i_drive_code,
  input wire logic i_closed_loop,
  input wire logic i_fb_brake_req,
  input wire logic i_brake_near_done,
  // interpreted drive
  output dii_pkg::dii_amp_t o_amp,
  output logic o_brake,
  output logic o_gain_reduce,
  output dii_pkg::dii_mode_t o_mode,
  // timing selections
  output logic o_sample_tick,
  output logic [1:0] o_blanking_sel,
  output logic [1:0] o_current_decay_period
);
  import dii_pkg::*;

  // ==========================================================
  // control register
  logic [7:0] drive_interpretation_control;
  wire logic hit = (i_reg_addr == `DII_CTRL_ADDR);
  wire logic wr_hit = i_reg_wr && hit;
  wire logic rd_hit = i_reg_rd && hit;
  wire logic input_polarity_mode = drive_interpretation_control[`DII_POL_BIT];
  wire logic brake_gain_reduce = drive_interpretation_control[`DII_BGR_BIT];
  wire logic [1:0] sample_sel =
    drive_interpretation_control[`DII_ST_HI:`DII_ST_LO];
  // bits 3:0 are only passed on; their meaning lives downstream
  wire logic [1:0] blanking_field =
    drive_interpretation_control[`DII_BLK_HI:`DII_BLK_LO];
  wire logic [1:0] decay_field =
    drive_interpretation_control[`DII_DEC_HI:`DII_DEC_LO];
  // unmapped reads return zero
  wire logic [7:0] next_rdata =
    rd_hit ? drive_interpretation_control : 8'h00;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      drive_interpretation_control <= `DII_CTRL_RST;
    end else if (wr_hit) begin
      drive_interpretation_control <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= next_rdata;
    end
  end

  // ==========================================================
  // mode decode
  // loop state only matters once bidirectional input is chosen
  dii_mode_t next_mode;
  always_comb begin
    if (!input_polarity_mode) begin
      next_mode = DII_UNIDIR;
    end else if (i_closed_loop) begin
      next_mode = DII_BIDIR_CLOSED;
    end else begin
      next_mode = DII_BIDIR_OPEN;
    end
  end

  // ==========================================================
  // amplitude mapping, linear except in closed loop, where codes up to the midpoint give zero
  wire logic [7:0] centered = i_drive_code ^ `DII_SIGN_FLIP;
  wire dii_amp_t amp_uni = {1'b0, i_drive_code};
  wire dii_amp_t amp_bidir = {centered, 1'b0};
  wire logic above_mid = (i_drive_code > `DII_MID_CODE);
  wire logic below_mid = (i_drive_code < `DII_MID_CODE);
  // the exact midpoint gives zero, like everything below it
  wire dii_amp_t amp_closed = above_mid ? amp_bidir : `DII_ZERO_AMP;

  dii_amp_t next_amp;
  logic next_brake;
  always_comb begin
    case (next_mode)
      DII_UNIDIR: begin
        next_amp = amp_uni;
        next_brake = i_fb_brake_req;
      end
      DII_BIDIR_OPEN: begin
        next_amp = amp_bidir;
        next_brake = below_mid;
      end
      DII_BIDIR_CLOSED: begin
        next_amp = amp_closed;
        next_brake = i_fb_brake_req;
      end
      default: begin
        next_amp = `DII_ZERO_AMP;
        next_brake = 1'b0;
      end
    endcase
  end

  // lower gain only while a brake is close to finishing
  wire logic next_gain_reduce =
    brake_gain_reduce && next_brake && i_brake_near_done;

  // each output has its own flop, all launched on the same edge
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_amp <= `DII_ZERO_AMP;
    end else begin
      o_amp <= next_amp;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_brake <= 1'b0;
    end else begin
      o_brake <= next_brake;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_gain_reduce <= 1'b0;
    end else begin
      o_gain_reduce <= next_gain_reduce;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mode <= DII_BIDIR_OPEN;
    end else begin
      o_mode <= next_mode;
    end
  end

  // ==========================================================
  // sampling period and timing fields
  // the timer restarts on any period change, so a new setting acts at once
  dii_tmr_if tmr_link ();
  logic [15:0] period_sel;
  always_comb begin
    case (sample_sel)
      2'h0: period_sel = P_SAMPLE_CYC_0;
      2'h1: period_sel = P_SAMPLE_CYC_1;
      2'h2: period_sel = P_SAMPLE_CYC_2;
      default: period_sel = P_SAMPLE_CYC_3;
    endcase
  end
  assign tmr_link.period_cycles = period_sel;

  dii_sample_timer u_timer (
    .i_clk_sys (i_clk_sys),
    .i_rst_n (i_rst_n),
    .tmr (tmr_link)
  );

  // tick passes one more flop so the port leaves a register
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sample_tick <= 1'b0;
    end else begin
      o_sample_tick <= tmr_link.tick;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_blanking_sel <= 2'h0;
    end else begin
      o_blanking_sel <= blanking_field;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_current_decay_period <= 2'h0;
    end else begin
      o_current_decay_period <= decay_field;
    end
  end

endmodule : dii_top

//--- tb/dii_top_monitor.sv
/* Port checker for dii_top.
   Assumes one clock domain; attached by the bind below. */
`timescale 1ns/1ps
`include "dii_consts.svh"
module dii_top_monitor (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // register access
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  // drive input and loop state
  input wire logic [7:0] i_drive_code,
  input wire logic i_closed_loop,
  input wire logic i_fb_brake_req,
  input wire logic i_brake_near_done,
  // interpreted drive and timing
  input wire dii_pkg::dii_amp_t o_amp,
  input wire logic o_brake,
  input wire logic o_gain_reduce,
  input wire dii_pkg::dii_mode_t o_mode,
  input wire logic o_sample_tick,
  input wire logic [1:0] o_blanking_sel,
  input wire logic [1:0] o_current_decay_period
);
  import dii_pkg::*;
  // ==========
  // port relations
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  property p_unidir;
    o_mode == DII_UNIDIR |-> o_amp == 9'($past(i_drive_code))
      && o_brake == $past(i_fb_brake_req);
  endproperty
  a_unidir: assert property (p_unidir) else $error("unidir map");
  property p_open;
    o_mode == DII_BIDIR_OPEN |-> o_brake == ($past(i_drive_code) < 8'h80)
      && o_amp == 9'(2 * (int'($past(i_drive_code)) - 128));
  endproperty
  a_open: assert property (p_open) else $error("open map");
  property p_closed;
    o_mode == DII_BIDIR_CLOSED |-> o_brake == $past(i_fb_brake_req)
      && o_amp == ($past(i_drive_code) > 8'h80 ?
      9'(2 * (int'($past(i_drive_code)) - 128)) : 9'h000);
  endproperty
  a_closed: assert property (p_closed) else $error("closed map");
  property p_mode;
    o_mode != DII_UNIDIR |->
      (o_mode == DII_BIDIR_CLOSED) == $past(i_closed_loop);
  endproperty
  a_mode: assert property (p_mode) else $error("loop mode");
  property p_gain;
    o_gain_reduce |-> $past(i_brake_near_done) && o_brake;
  endproperty
  a_gain: assert property (p_gain) else $error("gain reduce");
  property p_tick;
    o_sample_tick |=> (!o_sample_tick) [*3];
  endproperty
  a_tick: assert property (p_tick) else $error("tick width");
  property p_wr;
    i_reg_wr && i_reg_addr == `DII_CTRL_ADDR |-> ##2
      {o_blanking_sel, o_current_decay_period} == $past(i_reg_wdata[3:0], 2);
  endproperty
  a_wr: assert property (p_wr) else $error("write effect");
  property p_rd;
    i_reg_rd && i_reg_addr == `DII_CTRL_ADDR |=>
      o_reg_rdata[3:0] == {o_blanking_sel, o_current_decay_period};
  endproperty
  a_rd: assert property (p_rd) else $error("read data");
  property p_rd0;
    i_reg_rd && i_reg_addr != `DII_CTRL_ADDR |=> o_reg_rdata == 8'h00;
  endproperty
  a_rd0: assert property (p_rd0) else $error("unmapped read");
  c_unidir: cover property (o_mode == DII_UNIDIR);
  c_tick: cover property (o_sample_tick);
  c_gain: cover property (o_gain_reduce);
endmodule : dii_top_monitor
bind dii_top dii_top_monitor u_dii_mon (
  .i_clk_sys (i_clk_sys),
  .i_rst_n (i_rst_n),
  .i_reg_addr (i_reg_addr),
  .i_reg_wr (i_reg_wr),
  .i_reg_rd (i_reg_rd),
  .i_reg_wdata (i_reg_wdata),
  .o_reg_rdata (o_reg_rdata),
  .i_drive_code (i_drive_code),
  .i_closed_loop (i_closed_loop),
  .i_fb_brake_req (i_fb_brake_req),
  .i_brake_near_done (i_brake_near_done),
  .o_amp (o_amp),
  .o_brake (o_brake),
  .o_gain_reduce (o_gain_reduce),
  .o_mode (o_mode),
  .o_sample_tick (o_sample_tick),
  .o_blanking_sel (o_blanking_sel),
  .o_current_decay_period (o_current_decay_period)
);

//--- tb/drive_input_interpreter_tb.sv
/* Self-checking bench for dii_top with a behavioural model.
   Assumes short sampling periods 4, 6, 8 and 10 cycles. */
`timescale 1ns/1ps
`include "dii_consts.svh"
module drive_input_interpreter_tb;
  import dii_pkg::*;
  logic i_clk_sys = 1'b0, i_rst_n = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic i_closed_loop = 1'b0, i_fb_brake_req = 1'b0, i_brake_near_done = 1'b0;
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, i_drive_code = 8'h80;
  logic [7:0] o_reg_rdata;
  dii_amp_t o_amp;
  dii_mode_t o_mode;
  logic o_brake, o_gain_reduce, o_sample_tick;
  logic [1:0] o_blanking_sel, o_current_decay_period;
  integer errors = 0, cmp_count = 0, seed = 32'hD83C, m, k, s, n, e;
  int per [4] = '{4, 6, 8, 10};
  dii_top #(
    .P_SAMPLE_CYC_0 (16'h0004),
    .P_SAMPLE_CYC_1 (16'h0006),
    .P_SAMPLE_CYC_2 (16'h0008),
    .P_SAMPLE_CYC_3 (16'h000A)
  ) DUT (
    .i_clk_sys (i_clk_sys),
    .i_rst_n (i_rst_n),
    .i_reg_addr (i_reg_addr),
    .i_reg_wr (i_reg_wr),
    .i_reg_rd (i_reg_rd),
    .i_reg_wdata (i_reg_wdata),
    .o_reg_rdata (o_reg_rdata),
    .i_drive_code (i_drive_code),
    .i_closed_loop (i_closed_loop),
    .i_fb_brake_req (i_fb_brake_req),
    .i_brake_near_done (i_brake_near_done),
    .o_amp (o_amp),
    .o_brake (o_brake),
    .o_gain_reduce (o_gain_reduce),
    .o_mode (o_mode),
    .o_sample_tick (o_sample_tick),
    .o_blanking_sel (o_blanking_sel),
    .o_current_decay_period (o_current_decay_period)
  );
  initial forever #5 i_clk_sys = ~i_clk_sys;
  // ==========
  // tasks
  task chk(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wrr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    {i_reg_addr, i_reg_wdata, i_reg_wr} = {a, d, 1'b1};
    @(negedge i_clk_sys);
    i_reg_wr = 1'b0;
  endtask : wrr
  task rdr(input logic [7:0] a, input logic [7:0] x);
    @(negedge i_clk_sys);
    {i_reg_addr, i_reg_rd} = {a, 1'b1};
    @(negedge i_clk_sys);
    i_reg_rd = 1'b0;
    chk({1'b0, o_reg_rdata}, {1'b0, x});
  endtask : rdr
  task conclude;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // the tests need a few hundred cycles; 5000 cycles means a hang
  initial begin
    #50000;
    errors++;
    conclude();
  end
  // ==========
  // main sequence
  initial begin
    repeat (6) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    rdr(`DII_CTRL_ADDR, `DII_CTRL_RST);
    chk(9'(o_mode), 9'(DII_BIDIR_OPEN));
    rdr(8'h1B, 8'h00);
    for (m = 0; m < 3; m++) begin
      e = (m == 0) ? 8'h75 : (m == 1) ? 8'hF5 : 8'hB5;
      wrr(`DII_CTRL_ADDR, 8'(e));
      i_closed_loop = (m != 1);
      for (k = 0; k < 60; k++) begin
        i_drive_code = (k < 5) ? 8'(k * 64 - (k == 4)) : 8'($random(seed));
        {i_fb_brake_req, i_brake_near_done} = 2'($random(seed));
        @(negedge i_clk_sys);
        n = 2 * (int'(i_drive_code) - 128);
        n = (m == 0) ? int'(i_drive_code) : (m == 2 && n < 0) ? 0 : n;
        chk(o_amp, 9'(n));
        e = (m == 1) ? (i_drive_code < 8'h80) : i_fb_brake_req;
        chk(9'(o_brake), 9'(e));
        chk(9'(o_gain_reduce), 9'(e & i_brake_near_done & (m != 2)));
        chk(9'(o_mode), 9'(m));
      end
    end
    for (s = 0; s < 4; s++) begin
      e = {2'b10, 2'(s), 4'($random(seed))};
      wrr(`DII_CTRL_ADDR, 8'(e));
      @(negedge i_clk_sys);
      chk({5'h00, o_blanking_sel, o_current_decay_period}, 9'(e[3:0]));
      rdr(`DII_CTRL_ADDR, 8'(e));
      n = 0;
      while (o_sample_tick !== 1'b1 && n < 40) begin
        @(negedge i_clk_sys);
        n++;
      end
      n = 0;
      do begin
        @(negedge i_clk_sys);
        n++;
      end while (o_sample_tick !== 1'b1 && n < 40);
      chk(9'(n), 9'(per[s]));
    end
    wrr(8'h1B, 8'h00);
    rdr(`DII_CTRL_ADDR, 8'(e));
    conclude();
  end
endmodule : drive_input_interpreter_tb
